// >>> shared/gpr_pkg.sv
// Package for the GPIO port register core: offsets, field layouts, types.
// Assumes a 32-pin port and a plain byte-addressed register port.
package gpr_pkg;
    localparam int unsigned NUM_PINS = 32;
    localparam int unsigned ADDR_W = 12;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [11:0] OFS_DRIVE_LEVEL = 12'h504;
    localparam logic [11:0] OFS_DRIVE_SET = 12'h508;
    localparam logic [11:0] OFS_DRIVE_CLR = 12'h50c;
    localparam logic [11:0] OFS_PAD_LEVEL = 12'h510;
    localparam logic [11:0] OFS_ORIENT = 12'h514;
    localparam logic [11:0] OFS_ORIENT_SET = 12'h518;
    localparam logic [11:0] OFS_ORIENT_CLR = 12'h51c;
    localparam logic [11:0] OFS_SENSE_HIT = 12'h520;
    localparam logic [11:0] OFS_WAKE_SELECT = 12'h524;
    localparam logic [11:0] OFS_INPUT_DISC = 12'h600;
    localparam logic [11:0] OFS_SENSE_EN = 12'h604;
    localparam logic [11:0] OFS_SENSE_POL = 12'h608;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h610;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h614;

    // ****************************************************************
    // Reset values and fields
    // ****************************************************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam int unsigned WAKE_SEL_BIT = 0;
    localparam int unsigned IRQ_HIT_BIT = 0;
    localparam int unsigned IRQ_WAKE_BIT = 1;
    localparam int unsigned IRQ_W = 2;
    localparam logic [1:0] RST_IRQ = 2'h0;

    typedef enum logic [0:0]
    {
        GPR_WAKE_DIRECT = 1'h0,
        GPR_WAKE_LATCHED = 1'h1
    } gpr_wake_sel_e;

    typedef struct packed
    {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } gpr_bus_req_s;

    typedef struct packed
    {
        logic [31:0] enable;
        logic [31:0] level;
    } gpr_pad_drive_s;
endpackage

// >>> src/gpr_sync.sv
// Two-flop synchroniser for a vector of pad inputs.
// Assumes the inputs are asynchronous to sys_clk_i.
`timescale 1ns/10ps
module gpr_sync
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [31:0] async_i,
    output logic [31:0] sync_o
);
    logic [31:0] meta_r;
    logic [31:0] sync_r;

    // First stage is read only by the second stage
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            meta_r <= gpr_pkg::RST_WORD;
            sync_r <= gpr_pkg::RST_WORD;
        end
        else
        begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// >>> src/gpr_top.sv
// GPIO port register core: drive, direction, pad read, sense flags, wake.
// Assumes pad inputs are asynchronous; register port is on sys_clk_i.
//
// Summary of operation
// R1 - Drive register holds one bit per pin: 0 drives low, 1 drives high.
// R2 - Writing ones to the drive set alias sets those drive bits.
// R3 - Reading either drive alias returns the drive register.
// R4 - Drive clear alias clears selected drive bits, others untouched.
// R5 - Pad level register is read-only and shows each pin's input level.
// R6 - Orientation register: 0 makes pin input, 1 makes it output.
// R7 - Writing ones to orientation set alias makes those pins outputs.
// R8 - Writing ones to orientation clear alias makes those pins inputs.
// R9 - Reading either orientation alias returns the orientation register.
// R10 - Sense flag bit shows whether the pin met its sense condition.
// R11 - Writing one to a sense flag bit clears it.
// R12 - Sticky wake is high while any sense flag is set.
// R13 - Flags left set after a clear write give a fresh wake rising edge.
// R14 - Port wake follows raw sense by default, sticky wake when selected.
// R15 - Disconnected input buffer hides pin from pad read and sensing.
// R16 - Drive clear alias: ones clear bits, zeros leave them alone.
// R17 - Sense flags stay set after the condition goes until cleared.
`timescale 1ns/10ps
module gpr_top
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [31:0] pad_in_i,
    output logic [31:0] pad_out_o,
    output logic [31:0] pad_oe_o,
    output logic port_wake_o,
    output logic irq_o
);
    // ****************************************************************
    // Request bundle and address decode
    // ****************************************************************
    gpr_pkg::gpr_bus_req_s req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    // ****************************************************************
    // Update helpers
    // ****************************************************************
    // Full write wins over the aliases; only one address can hit anyway
    function automatic logic [31:0] word_update
    (
        input logic [31:0] cur,
        input logic [31:0] wdata,
        input logic wr_full,
        input logic wr_set,
        input logic wr_clr
    );
        logic [31:0] res;
        res = cur;
        if (wr_full)
            res = wdata;
        else if (wr_set)
            res = cur | wdata;
        else if (wr_clr)
            res = cur & ~wdata;
        return res;
    endfunction

    // Set beats clear, so an event in the clearing cycle is never lost
    function automatic logic [31:0] flag_update
    (
        input logic [31:0] cur,
        input logic [31:0] clr,
        input logic [31:0] ev
    );
        return (cur & ~clr) | ev;
    endfunction

    wire wr_drive = req.wr && hit(req.addr, gpr_pkg::OFS_DRIVE_LEVEL);
    wire wr_drive_set = req.wr && hit(req.addr, gpr_pkg::OFS_DRIVE_SET);
    wire wr_drive_clr = req.wr && hit(req.addr, gpr_pkg::OFS_DRIVE_CLR);
    wire wr_orient = req.wr && hit(req.addr, gpr_pkg::OFS_ORIENT);
    wire wr_orient_set = req.wr && hit(req.addr, gpr_pkg::OFS_ORIENT_SET);
    wire wr_orient_clr = req.wr && hit(req.addr, gpr_pkg::OFS_ORIENT_CLR);
    wire wr_hit = req.wr && hit(req.addr, gpr_pkg::OFS_SENSE_HIT);
    wire wr_wsel = req.wr && hit(req.addr, gpr_pkg::OFS_WAKE_SELECT);
    wire wr_disc = req.wr && hit(req.addr, gpr_pkg::OFS_INPUT_DISC);
    wire wr_sen = req.wr && hit(req.addr, gpr_pkg::OFS_SENSE_EN);
    wire wr_spol = req.wr && hit(req.addr, gpr_pkg::OFS_SENSE_POL);
    wire wr_ists = req.wr && hit(req.addr, gpr_pkg::OFS_IRQ_STATUS);
    wire wr_imsk = req.wr && hit(req.addr, gpr_pkg::OFS_IRQ_MASK);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0] drive_level_r;
    logic [31:0] drive_level_nxt;
    logic [31:0] orient_r;
    logic [31:0] orient_nxt;
    logic [31:0] sense_hit_r;
    logic [31:0] sense_hit_nxt;
    logic [31:0] input_disc_r;
    logic [31:0] input_disc_nxt;
    logic [31:0] sense_en_r;
    logic [31:0] sense_en_nxt;
    logic [31:0] sense_pol_r;
    logic [31:0] sense_pol_nxt;
    gpr_pkg::gpr_wake_sel_e wake_sel_r;
    gpr_pkg::gpr_wake_sel_e wake_sel_nxt;
    logic [1:0] irq_sts_r;
    logic [1:0] irq_sts_nxt;
    logic [1:0] irq_msk_r;
    logic [1:0] irq_msk_nxt;
    logic sticky_wake_r;
    logic sticky_wake_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // ****************************************************************
    // Pad input path
    // ****************************************************************
    logic [31:0] pad_sync;

    // Pads are asynchronous to the clock, so two flops come first
    gpr_sync u_sync
    (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .async_i(pad_in_i),
        .sync_o(pad_sync)
    );

    // R15 - buffer gating
    // Disconnected buffer reads low and never senses
    wire [31:0] pad_level = pad_sync & ~input_disc_r;
    wire [31:0] pin_live = ~input_disc_r;

    // R10 - sense condition
    // Polarity bit 1 senses high, 0 senses low
    wire [31:0] sense_raw = sense_en_r & pin_live & ~(pad_level ^ sense_pol_r);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // R1 - direct drive write
    // R2 - set alias
    // R4 - clear alias
    // R16 - ones clear only
    assign drive_level_nxt = word_update(drive_level_r, req.wdata, wr_drive, wr_drive_set,
                                         wr_drive_clr);

    // R6 - direct orientation write
    // R7 - set alias
    // R8 - clear alias
    assign orient_nxt = word_update(orient_r, req.wdata, wr_orient, wr_orient_set,
                                    wr_orient_clr);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    assign input_disc_nxt = wr_disc ? req.wdata : input_disc_r;
    assign sense_en_nxt = wr_sen ? req.wdata : sense_en_r;
    assign sense_pol_nxt = wr_spol ? req.wdata : sense_pol_r;
    assign wake_sel_nxt = wr_wsel ? gpr_pkg::gpr_wake_sel_e'(req.wdata[gpr_pkg::WAKE_SEL_BIT])
                                  : wake_sel_r;
    assign irq_msk_nxt = wr_imsk ? req.wdata[gpr_pkg::IRQ_W-1:0] : irq_msk_r;

    // ****************************************************************
    // Sense flags and wake
    // ****************************************************************
    // R11 - write one clears
    // R17 - sticky until cleared
    // New hits win over the clear in the same cycle
    wire [31:0] hit_clr = wr_hit ? req.wdata : gpr_pkg::RST_WORD;
    assign sense_hit_nxt = flag_update(sense_hit_r, hit_clr, sense_raw);

    // R12 - sticky wake level
    // R13 - fresh edge after clear
    // A clear write with flags remaining drops the line for one cycle
    wire hit_any_nxt = |sense_hit_nxt;
    assign sticky_wake_nxt = hit_any_nxt && !(wr_hit && sticky_wake_r);

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    // Events: any new sense hit, and rising edge of sticky wake
    wire ev_hit = |(sense_raw & ~sense_hit_r);
    wire ev_wake = sticky_wake_nxt && !sticky_wake_r;
    wire [1:0] irq_ev = {ev_wake, ev_hit};
    wire [1:0] irq_clr = wr_ists ? req.wdata[gpr_pkg::IRQ_W-1:0] : gpr_pkg::RST_IRQ;
    // Same flag rule as the sense flags, widened to one word
    wire [31:0] irq_sts_word = flag_update(32'(irq_sts_r), 32'(irq_clr), 32'(irq_ev));
    assign irq_sts_nxt = irq_sts_word[gpr_pkg::IRQ_W-1:0];

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // R3 - drive aliases read back
    // R5 - pad level read only
    // R9 - orientation aliases read back
    // Zero outside read replies, so a stale word never looks like data
    always_comb
    begin
        rdata_nxt = gpr_pkg::RST_WORD;
        if (req.rd)
        begin
            unique case (req.addr)
                gpr_pkg::OFS_DRIVE_LEVEL,
                gpr_pkg::OFS_DRIVE_SET,
                gpr_pkg::OFS_DRIVE_CLR: rdata_nxt = drive_level_r;
                gpr_pkg::OFS_PAD_LEVEL: rdata_nxt = pad_level;
                gpr_pkg::OFS_ORIENT,
                gpr_pkg::OFS_ORIENT_SET,
                gpr_pkg::OFS_ORIENT_CLR: rdata_nxt = orient_r;
                gpr_pkg::OFS_SENSE_HIT: rdata_nxt = sense_hit_r;
                gpr_pkg::OFS_WAKE_SELECT: rdata_nxt = 32'(wake_sel_r);
                gpr_pkg::OFS_INPUT_DISC: rdata_nxt = input_disc_r;
                gpr_pkg::OFS_SENSE_EN: rdata_nxt = sense_en_r;
                gpr_pkg::OFS_SENSE_POL: rdata_nxt = sense_pol_r;
                gpr_pkg::OFS_IRQ_STATUS: rdata_nxt = 32'(irq_sts_r);
                gpr_pkg::OFS_IRQ_MASK: rdata_nxt = 32'(irq_msk_r);
                default: rdata_nxt = gpr_pkg::RST_WORD;
            endcase
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            drive_level_r <= gpr_pkg::RST_WORD;
            orient_r <= gpr_pkg::RST_WORD;
            sense_hit_r <= gpr_pkg::RST_WORD;
            sticky_wake_r <= 1'b0;
            rdata_r <= gpr_pkg::RST_WORD;
            irq_sts_r <= gpr_pkg::RST_IRQ;
        end
        else
        begin
            drive_level_r <= drive_level_nxt;
            orient_r <= orient_nxt;
            sense_hit_r <= sense_hit_nxt;
            sticky_wake_r <= sticky_wake_nxt;
            rdata_r <= rdata_nxt;
            irq_sts_r <= irq_sts_nxt;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            input_disc_r <= gpr_pkg::RST_WORD;
            sense_en_r <= gpr_pkg::RST_WORD;
            sense_pol_r <= gpr_pkg::RST_WORD;
            wake_sel_r <= gpr_pkg::GPR_WAKE_DIRECT;
            irq_msk_r <= gpr_pkg::RST_IRQ;
        end
        else
        begin
            input_disc_r <= input_disc_nxt;
            sense_en_r <= sense_en_nxt;
            sense_pol_r <= sense_pol_nxt;
            wake_sel_r <= wake_sel_nxt;
            irq_msk_r <= irq_msk_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Level is driven even for input pins, so software can preset it
    gpr_pkg::gpr_pad_drive_s pad_drv;
    assign pad_drv = '{enable: orient_r, level: drive_level_r};
    assign pad_out_o = pad_drv.level;
    assign pad_oe_o = pad_drv.enable;
    assign reg_rdata_o = rdata_r;

    // R14 - wake source select
    // Direct mode is combinational from synced pads; latched mode is one flop later
    assign port_wake_o = (wake_sel_r == gpr_pkg::GPR_WAKE_LATCHED) ? sticky_wake_r
                                                                   : (|sense_raw);
    assign irq_o = |(irq_sts_r & irq_msk_r);
endmodule

// >>> tb/gpio_port_registers_test.sv
// Bench for the port register core: register tasks and sense sequences.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/10ps
module gpio_port_registers_test;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] ext_lvl = 32'h0;
    logic [31:0] reg_rdata_o, pad_in_i, pad_out_o, pad_oe_o;
    logic port_wake_o, irq_o;
    logic wake_q = 1'b0;
    int num_errors = 0, n_tests = 0, rises = 0, r0;
    gpr_top i_dut (.sys_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .pad_in_i, .pad_out_o, .pad_oe_o, .port_wake_o, .irq_o);
    gpr_pins i_pins (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_i(ext_lvl), .pad_o(pad_in_i));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i)
    begin
        wake_q <= port_wake_o;
        if (port_wake_o === 1'b1 && wake_q === 1'b0)
            rises <= rises + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, e);
    endtask
    // Pads pass a two-flop sync, so give them a few cycles
    task automatic setx(input logic [31:0] v);
        @(posedge sys_clk_i);
        ext_lvl <= v;
        repeat (4) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #50000;
        num_errors++;
        final_report();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(12'h504, 32'h0);
        rd(12'h510, 32'h0);
        rd(12'h514, 32'h0);
        rd(12'h520, 32'h0);
        rd(12'h7fc, 32'h0);
        $display("test reset done");
        wr(12'h504, 32'ha5a5_0f0f);
        rd(12'h504, 32'ha5a5_0f0f);
        wr(12'h508, 32'h0000_00f0);
        rd(12'h50c, 32'ha5a5_0fff);
        wr(12'h50c, 32'h0000_0f00);
        rd(12'h508, 32'ha5a5_00ff);
        chk(pad_out_o, 32'ha5a5_00ff);
        $display("test drive done");
        wr(12'h514, 32'hffff_0000);
        wr(12'h518, 32'h0000_00ff);
        wr(12'h51c, 32'hff00_0000);
        rd(12'h518, 32'h00ff_00ff);
        rd(12'h51c, 32'h00ff_00ff);
        chk(pad_oe_o, 32'h00ff_00ff);
        $display("test orientation done");
        // Driven pins loop back, the rest show the outside level
        setx(32'h1234_5678);
        rd(12'h510, 32'h12a5_56ff);
        wr(12'h510, 32'h0);
        rd(12'h510, 32'h12a5_56ff);
        wr(12'h600, 32'h0000_000f);
        setx(32'h1234_5678);
        rd(12'h510, 32'h12a5_56f0);
        wr(12'h600, 32'h0);
        $display("test pad read done");
        // Polarity first, so enabling never catches a stray low level
        wr(12'h608, 32'hc000_0000);
        wr(12'h604, 32'hc000_0000);
        setx(32'hd234_5678);
        chk1(port_wake_o, 1'b1);
        rd(12'h520, 32'hc000_0000);
        setx(32'h1234_5678);
        chk1(port_wake_o, 1'b0);
        rd(12'h520, 32'hc000_0000);
        chk1(irq_o, 1'b0);
        wr(12'h614, 32'h3);
        chk1(irq_o, 1'b1);
        wr(12'h524, 32'h1);
        setx(32'h1234_5678);
        chk1(port_wake_o, 1'b1);
        r0 = rises;
        wr(12'h520, 32'h4000_0000);
        setx(32'h1234_5678);
        chk(32'(rises - r0), 32'h1);
        rd(12'h520, 32'h8000_0000);
        chk1(port_wake_o, 1'b1);
        wr(12'h520, 32'h8000_0000);
        setx(32'h1234_5678);
        chk1(port_wake_o, 1'b0);
        rd(12'h520, 32'h0);
        wr(12'h610, 32'h3);
        chk1(irq_o, 1'b0);
        $display("test sense done");
        // Low-level sense, first with the input buffers cut off
        wr(12'h600, 32'hc000_0000);
        wr(12'h608, 32'h0);
        setx(32'h1234_5678);
        rd(12'h520, 32'h0);
        chk1(port_wake_o, 1'b0);
        wr(12'h600, 32'h0);
        setx(32'h1234_5678);
        rd(12'h520, 32'hc000_0000);
        chk1(port_wake_o, 1'b1);
        $display("test sense low done");
        // Mid-run reset brings every register except pad level back to zero
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(12'h520, 32'h0);
        rd(12'h504, 32'h0);
        chk(pad_oe_o, 32'h0);
        chk1(port_wake_o, 1'b0);
        $display("test reset again done");
        final_report();
    end
endmodule
bind gpr_top gpr_top_assertions i_chk (.sys_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pad_in_i, .pad_out_o, .pad_oe_o, .port_wake_o, .irq_o);

// >>> tb/gpr_pins.sv
// Partner model: outside circuitry on the 32 port pins.
// Assumes the bench sets the level each undriven pin sees.
`timescale 1ns/10ps
module gpr_pins
(
    input wire logic [31:0] pad_out_i,
    input wire logic [31:0] pad_oe_i,
    input wire logic [31:0] ext_i,
    output logic [31:0] pad_o
);
    // Pins the port drives read back their own level, others see outside
    assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

// >>> tb/gpr_top_assertions.sv
// Checker for the port register core, watching drive, direction, read data.
// Assumes it is bound to gpr_top and sees only its ports.
`timescale 1ns/10ps
module gpr_top_assertions
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [31:0] pad_in_i,
    input wire logic [31:0] pad_out_o,
    input wire logic [31:0] pad_oe_o,
    input wire logic port_wake_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    wire logic w_drv = reg_wr_i && reg_addr_i == gpr_pkg::OFS_DRIVE_LEVEL;
    wire logic w_set = reg_wr_i && reg_addr_i == gpr_pkg::OFS_DRIVE_SET;
    wire logic w_clr = reg_wr_i && reg_addr_i == gpr_pkg::OFS_DRIVE_CLR;
    wire logic w_ori = reg_wr_i && reg_addr_i == gpr_pkg::OFS_ORIENT;
    wire logic w_oset = reg_wr_i && reg_addr_i == gpr_pkg::OFS_ORIENT_SET;
    wire logic w_oclr = reg_wr_i && reg_addr_i == gpr_pkg::OFS_ORIENT_CLR;
    wire logic r_drv = reg_rd_i && reg_addr_i[11:3] == 9'h0a1;
    wire logic r_ori = reg_rd_i && reg_addr_i[11:3] == 9'h0a3;
    // ****************************************************************
    // Drive and direction registers
    // ****************************************************************
    drive_write_a: assert property (w_drv |=> pad_out_o == $past(reg_wdata_i))
        else $error("drive write not applied");
    drive_set_a: assert property (w_set |=> pad_out_o == ($past(pad_out_o) | $past(reg_wdata_i)))
        else $error("drive set alias wrong");
    drive_clear_a: assert property (w_clr |=> pad_out_o == ($past(pad_out_o) & ~$past(reg_wdata_i)))
        else $error("drive clear alias wrong");
    drive_hold_a: assert property (!(w_drv || w_set || w_clr) |=> $stable(pad_out_o))
        else $error("drive level moved without write");
    drive_alias_read_a: assert property (r_drv |=> reg_rdata_o == $past(pad_out_o))
        else $error("drive alias read wrong");
    orient_write_a: assert property (w_ori |=> pad_oe_o == $past(reg_wdata_i))
        else $error("orientation write not applied");
    orient_set_a: assert property (w_oset |=> pad_oe_o == ($past(pad_oe_o) | $past(reg_wdata_i)))
        else $error("orientation set alias wrong");
    orient_clear_a: assert property (w_oclr |=> pad_oe_o == ($past(pad_oe_o) & ~$past(reg_wdata_i)))
        else $error("orientation clear alias wrong");
    orient_alias_read_a: assert property (r_ori |=> reg_rdata_o == $past(pad_oe_o))
        else $error("orientation alias read wrong");
endmodule
